/* logic/mfv_pkg.sv */
// Constants, types and register map of the flow-control and tag-match block.
// Assumes a 40 MHz AHB-Lite clock; the receive and transmit paths are byte streams.
//
// What this block does
// RL1 - Management data holds 16-bit PHY read result and 16-bit write value
// RL2 - Writing flow control with busy set sends a pause frame with pause time
// RL3 - Busy stays one during the pause frame, clears when it is fully sent
// RL4 - Software checks busy is zero before writing flow control again
// RL5 - Upper sixteen flow control bits hold the transmitted pause time
// RL6 - Software spaces flow control writes by at least four clocks
// RL7 - Zero-quanta disable and pause low threshold are inert reserved fields
// RL8 - Unicast pause detect also accepts pause frames to own station address
// RL9 - Without unicast detect only the reserved multicast pause address counts
// RL10 - Receive flow enable decodes pause frames and halts transmitter that long
// RL11 - Full duplex: transmit flow enable permits pause frames, else none sent
// RL12 - Half duplex: transmit flow enable turns back-pressure on or off
// RL13 - Half duplex back-pressure jams the transmitter on each new received frame
// RL14 - Bytes 13-14 equal 0x8100 and next two match tag sets VLAN status
// RL15 - Tagged frames raise the legal frame length from 1518 to 1522
// RL16 - Twelve-bit compare uses tag bits 11:0 only, else all sixteen
// RL17 - Tag bits 15:13 priority, bit 12 format indicator, 11:0 VID
// RL18 - Zero compared tag skips compare; every 0x8100 frame is VLAN
// RL19 - Software writes the tag register as words, four link clocks apart
// RL20 - Pause frame: 01-80-c2-00-00-01, type 0x8808, opcode 0x0001, pause time
package mfv_pkg;
    localparam logic [7:0] MFV_ADDR_FLOW = 8'h18;
    localparam logic [7:0] MFV_ADDR_VLAN = 8'h1c;
    localparam logic [7:0] MFV_ADDR_MGMT = 8'h14;
    localparam logic [7:0] MFV_ADDR_MODE = 8'h30;
    localparam logic [7:0] MFV_ADDR_STAT = 8'h34;
    localparam int MFV_PT_LSB = 16;
    localparam int MFV_UP_BIT = 3;
    localparam int MFV_RFE_BIT = 2;
    localparam int MFV_TFE_BIT = 1;
    localparam int MFV_BUSY_BIT = 0;
    localparam int MFV_ETV_BIT = 16;
    localparam logic [31:0] MFV_FLOW_RESET = 32'h0000_0000;
    localparam logic [31:0] MFV_FLOW_WMASK = 32'hffff_00bf;
    localparam logic [47:0] MFV_PAUSE_DA = 48'h0180_c200_0001;
    localparam logic [15:0] MFV_CTRL_TYPE = 16'h8808;
    localparam logic [15:0] MFV_PAUSE_OP = 16'h0001;
    localparam logic [15:0] MFV_VLAN_TYPE = 16'h8100;
    localparam logic [10:0] MFV_MAX_LEN = 11'd1518;
    localparam logic [10:0] MFV_MAX_LEN_TAG = 11'd1522;
    localparam logic [5:0] MFV_PAUSE_LEN = 6'd60;
    localparam logic [15:0] MFV_QUANTUM_CYC = 16'd64;
    typedef struct packed {
        logic valid;
        logic sof;
        logic eof;
        logic [7:0] data;
    } mfv_byte_type;
    typedef enum logic [2:0] {
        MFV_TX_IDLE = 3'b001,
        MFV_TX_SEND = 3'b010,
        MFV_TX_DONE = 3'b100
    } mfv_tx_state_type;
endpackage

/* logic/mfv_rx_parse.sv */
// Receive-side frame parser: pause decode and VLAN tag classification.
// Assumes one byte per valid beat with sof on the first and eof on the last.
`timescale 1ns/1ps
`default_nettype none
module mfv_rx_parse (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Received bytes and settings
    input wire mfv_pkg::mfv_byte_type rx_in,
    input wire logic [47:0] station_addr,
    input wire logic unicast_pause,
    input wire logic rx_flow_enable,
    input wire logic vid_only_compare,
    input wire logic [15:0] vlan_tag_value,
    // Results: flags are one-cycle pulses at end of frame; pause_quanta follows the captured time word
    output logic pause_hit,
    output logic [15:0] pause_quanta,
    output logic frame_done,
    output logic vlan_hit,
    output logic too_long
);
    import mfv_pkg::*;
    logic [10:0] cnt, next_cnt;
    logic [47:0] da, next_da;
    logic [15:0] w0, next_w0, w1, next_w1, w2, next_w2;
    logic nph, nfd, nvh, ntl;
    logic [15:0] npq;
    logic [15:0] tag_mask, tag_cmp;
    logic is_vlan, is_pause, da_ok;

    ////////////////////////////////////////////////////////////////////////
    // Capture destination, type and following words by byte count
    always_comb begin
        next_cnt = cnt;
        next_da = da;
        next_w0 = w0;
        next_w1 = w1;
        next_w2 = w2;
        if (rx_in.valid) begin
            next_cnt = rx_in.sof ? 11'd1 : ((cnt == 11'h7ff) ? cnt : cnt + 11'd1);
            if (rx_in.sof || cnt < 11'd6) begin
                next_da = {da[39:0], rx_in.data};
            end
            if (cnt == 11'd12 || cnt == 11'd13) begin
                next_w0 = {w0[7:0], rx_in.data};
            end
            if (cnt == 11'd14 || cnt == 11'd15) begin
                next_w1 = {w1[7:0], rx_in.data};
            end
            if (cnt == 11'd16 || cnt == 11'd17) begin
                next_w2 = {w2[7:0], rx_in.data};
            end
        end
    end

    // Classification, reported on the end-of-frame beat
    always_comb begin
        tag_mask = vid_only_compare ? 16'h0fff : 16'hffff; // [RL16] [RL17]
        tag_cmp = vlan_tag_value & tag_mask;
        is_vlan = (w0 == MFV_VLAN_TYPE) &&
                  ((tag_cmp == 16'h0000) || ((w1 & tag_mask) == tag_cmp)); // [RL14] [RL18]
        da_ok = (da == MFV_PAUSE_DA) || (unicast_pause && da == station_addr); // [RL8] [RL9]
        is_pause = rx_flow_enable && da_ok && w0 == MFV_CTRL_TYPE &&
                   w1 == MFV_PAUSE_OP; // [RL10]
        nfd = rx_in.valid && rx_in.eof;
        nph = nfd && is_pause;
        npq = w2;
        nvh = nfd && is_vlan;
        ntl = nfd && (next_cnt > (is_vlan ? MFV_MAX_LEN_TAG : MFV_MAX_LEN)); // [RL15]
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt <= 11'h000;
            da <= 48'h0;
            w0 <= 16'h0000;
            w1 <= 16'h0000;
            w2 <= 16'h0000;
            pause_hit <= 1'b0;
            pause_quanta <= 16'h0000;
            frame_done <= 1'b0;
            vlan_hit <= 1'b0;
            too_long <= 1'b0;
        end else begin
            cnt <= next_cnt;
            da <= next_da;
            w0 <= next_w0;
            w1 <= next_w1;
            w2 <= next_w2;
            pause_hit <= nph;
            pause_quanta <= npq;
            frame_done <= nfd;
            vlan_hit <= nvh;
            too_long <= ntl;
        end
    end
endmodule
`default_nettype wire

/* logic/mfv_top.sv */
// Flow control, back-pressure, pause decode and VLAN match with AHB-Lite registers.
// Assumes single-word AHB-Lite transfers and byte streams synchronous to hclk.
`timescale 1ns/1ps
`default_nettype none
module mfv_top (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Management data exchange
    input wire logic mgmt_read_done,
    input wire logic [15:0] mgmt_read_value,
    output logic [15:0] mgmt_data_value,
    // Received byte stream
    input wire mfv_pkg::mfv_byte_type rx_in,
    input wire logic [47:0] station_addr,
    // Pause frame transmit stream
    input wire logic tx_ready,
    output mfv_pkg::mfv_byte_type tx_out,
    // Transmitter control and receive status
    output logic tx_halt,
    output logic jam_request,
    output logic rx_vlan_status,
    output logic rx_too_long
);
    import mfv_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Register and bus state
    logic [31:0] flow_control_reg, next_flow;
    logic [16:0] vlan_tag_reg, next_vlan;
    logic [15:0] next_mgmt;
    logic full_duplex, next_fd;
    logic wr_pend, next_wr_pend;
    logic [7:0] wr_addr, next_wr_addr;
    logic [31:0] next_rdata;
    logic addr_phase, pause_start, pause_sent;
    logic busy, tx_flow_enable;

    // Transmit state
    mfv_tx_state_type tx_state, next_tx_state;
    logic [5:0] tx_idx, next_tx_idx;
    logic [15:0] tx_time, next_tx_time;
    mfv_byte_type next_tx_out;
    logic [7:0] tx_byte;

    // Pause timer
    logic [15:0] quanta, next_quanta;
    logic [15:0] qcyc, next_qcyc;
    logic next_halt, next_jam, next_vs, next_tl;

    logic p_hit, p_done, p_vlan, p_long;
    logic [15:0] p_quanta;

    assign busy = flow_control_reg[MFV_BUSY_BIT];
    assign tx_flow_enable = flow_control_reg[MFV_TFE_BIT];
    assign addr_phase = hsel && hready && htrans[1];

    ////////////////////////////////////////////////////////////////////////
    // Register writes happen in the data phase; reads are answered there too
    always_comb begin
        next_wr_pend = addr_phase && hwrite;
        next_wr_addr = addr_phase ? haddr[7:0] : wr_addr;
        next_flow = flow_control_reg;
        next_vlan = vlan_tag_reg;
        next_mgmt = mgmt_data_value;
        next_fd = full_duplex;
        pause_start = 1'b0;
        if (mgmt_read_done) begin
            next_mgmt = mgmt_read_value; // [RL1]
        end
        if (pause_sent || (full_duplex && !tx_flow_enable)) begin
            next_flow[MFV_BUSY_BIT] = 1'b0; // [RL3] [RL11]
        end
        if (wr_pend) begin
            if (wr_addr == MFV_ADDR_FLOW) begin
                // Reserved threshold and zero-quanta bits are stored but steer nothing
                next_flow = hwdata & MFV_FLOW_WMASK; // [RL5] [RL7]
                pause_start = full_duplex && hwdata[MFV_BUSY_BIT] &&
                              hwdata[MFV_TFE_BIT]; // [RL2] [RL11]
            end else if (wr_addr == MFV_ADDR_VLAN) begin
                next_vlan = hwdata[16:0]; // [RL17]
            end else if (wr_addr == MFV_ADDR_MGMT) begin
                next_mgmt = hwdata[15:0]; // [RL1]
            end else if (wr_addr == MFV_ADDR_MODE) begin
                next_fd = hwdata[0];
            end
        end
        next_rdata = 32'h0000_0000;
        // Freshest values, so a read right behind a landing write sees it
        if (addr_phase && !hwrite) begin
            if (haddr[7:0] == MFV_ADDR_FLOW) begin
                next_rdata = next_flow;
            end else if (haddr[7:0] == MFV_ADDR_VLAN) begin
                next_rdata = {15'h0000, next_vlan};
            end else if (haddr[7:0] == MFV_ADDR_MGMT) begin
                next_rdata = {16'h0000, next_mgmt};
            end else if (haddr[7:0] == MFV_ADDR_MODE) begin
                next_rdata = {31'h0, next_fd};
            end else if (haddr[7:0] == MFV_ADDR_STAT) begin
                next_rdata = {28'h0, rx_too_long, rx_vlan_status, jam_request, tx_halt};
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flow_control_reg <= MFV_FLOW_RESET;
            vlan_tag_reg <= 17'h00000;
            mgmt_data_value <= 16'h0000;
            full_duplex <= 1'b1;
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            flow_control_reg <= next_flow;
            vlan_tag_reg <= next_vlan;
            mgmt_data_value <= next_mgmt;
            full_duplex <= next_fd;
            wr_pend <= next_wr_pend;
            wr_addr <= next_wr_addr;
            hrdata <= next_rdata;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pause frame byte selection: DA, SA, type, opcode, time, zero pad
    always_comb begin
        tx_byte = 8'h00;
        if (tx_idx < 6'd6) begin
            tx_byte = MFV_PAUSE_DA[8'(47 - 8 * tx_idx) -: 8]; // [RL20]
        end else if (tx_idx < 6'd12) begin
            tx_byte = station_addr[8'(95 - 8 * tx_idx) -: 8];
        end else if (tx_idx == 6'd12) begin
            tx_byte = MFV_CTRL_TYPE[15:8]; // [RL20]
        end else if (tx_idx == 6'd13) begin
            tx_byte = MFV_CTRL_TYPE[7:0];
        end else if (tx_idx == 6'd14) begin
            tx_byte = MFV_PAUSE_OP[15:8];
        end else if (tx_idx == 6'd15) begin
            tx_byte = MFV_PAUSE_OP[7:0];
        end else if (tx_idx == 6'd16) begin
            tx_byte = tx_time[15:8]; // [RL2]
        end else if (tx_idx == 6'd17) begin
            tx_byte = tx_time[7:0];
        end
    end

    // Transmit sequencer; a byte leaves when tx_ready is seen with valid
    always_comb begin
        next_tx_state = tx_state;
        next_tx_idx = tx_idx;
        next_tx_time = tx_time;
        next_tx_out = tx_out;
        pause_sent = 1'b0;
        case (tx_state)
            MFV_TX_IDLE: begin
                next_tx_out = '0;
                if (pause_start) begin
                    next_tx_time = hwdata[31:MFV_PT_LSB]; // [RL5]
                    next_tx_idx = 6'd0;
                    next_tx_state = MFV_TX_SEND;
                end
            end
            MFV_TX_SEND: begin
                if (!tx_out.valid || tx_ready) begin
                    next_tx_out.valid = 1'b1;
                    next_tx_out.sof = (tx_idx == 6'd0);
                    next_tx_out.eof = (tx_idx == MFV_PAUSE_LEN - 6'd1);
                    next_tx_out.data = tx_byte;
                    next_tx_idx = tx_idx + 6'd1;
                    if (tx_idx == MFV_PAUSE_LEN - 6'd1) begin
                        next_tx_state = MFV_TX_DONE;
                    end
                end
            end
            MFV_TX_DONE: begin
                if (tx_ready) begin
                    next_tx_out = '0;
                    pause_sent = 1'b1; // [RL3]
                    next_tx_state = MFV_TX_IDLE;
                end
            end
            default: begin
                next_tx_state = MFV_TX_IDLE;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_state <= MFV_TX_IDLE;
            tx_idx <= 6'd0;
            tx_time <= 16'h0000;
            tx_out <= '0;
        end else begin
            tx_state <= next_tx_state;
            tx_idx <= next_tx_idx;
            tx_time <= next_tx_time;
            tx_out <= next_tx_out;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive parser instance
    mfv_rx_parse u_parse (
        .hclk(hclk),
        .hresetn(hresetn),
        .rx_in(rx_in),
        .station_addr(station_addr),
        .unicast_pause(flow_control_reg[MFV_UP_BIT]),
        .rx_flow_enable(flow_control_reg[MFV_RFE_BIT]),
        .vid_only_compare(vlan_tag_reg[MFV_ETV_BIT]),
        .vlan_tag_value(vlan_tag_reg[15:0]),
        .pause_hit(p_hit),
        .pause_quanta(p_quanta),
        .frame_done(p_done),
        .vlan_hit(p_vlan),
        .too_long(p_long)
    );

    // Pause timer halts transmit; half duplex back-pressure jams per frame
    always_comb begin
        next_quanta = quanta;
        next_qcyc = qcyc;
        if (p_hit) begin
            next_quanta = p_quanta; // [RL10]
            next_qcyc = MFV_QUANTUM_CYC;
        end else if (quanta != 16'h0000) begin
            if (qcyc == 16'd1) begin
                next_qcyc = MFV_QUANTUM_CYC;
                next_quanta = quanta - 16'd1;
            end else begin
                next_qcyc = qcyc - 16'd1;
            end
        end
        next_halt = (next_quanta != 16'h0000);
        next_jam = !full_duplex && tx_flow_enable && busy &&
                   rx_in.valid && rx_in.sof; // [RL12] [RL13]
        next_vs = p_done ? p_vlan : rx_vlan_status; // [RL14]
        next_tl = p_done ? p_long : rx_too_long; // [RL15]
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            quanta <= 16'h0000;
            qcyc <= 16'h0000;
            tx_halt <= 1'b0;
            jam_request <= 1'b0;
            rx_vlan_status <= 1'b0;
            rx_too_long <= 1'b0;
        end else begin
            quanta <= next_quanta;
            qcyc <= next_qcyc;
            tx_halt <= next_halt;
            jam_request <= next_jam;
            rx_vlan_status <= next_vs;
            rx_too_long <= next_tl;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    busy_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (tx_state == MFV_TX_SEND) |-> busy || !full_duplex) // [RL3]
        else $error("busy dropped during pause frame");
    busy_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
        pause_sent |=> !busy) // [RL3]
        else $error("busy not cleared after pause frame");
    pause_start_a: assert property (@(posedge hclk) disable iff (!hresetn)
        pause_start |=> (tx_state == MFV_TX_SEND) && tx_time == $past(hwdata[31:16])) // [RL2]
        else $error("pause frame not started with pause time");
    no_pause_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_pend && wr_addr == MFV_ADDR_FLOW && !hwdata[MFV_TFE_BIT] &&
         tx_state == MFV_TX_IDLE) |=> tx_state == MFV_TX_IDLE) // [RL11]
        else $error("pause sent with flow control disabled");
    pause_type_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (tx_out.valid && tx_idx == 6'd13 && tx_state == MFV_TX_SEND && tx_ready)
        |-> tx_out.data == MFV_CTRL_TYPE[15:8]) // [RL20]
        else $error("wrong control type byte");
    halt_on_pause_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (p_hit && p_quanta != 16'h0000) |=> tx_halt) // [RL10]
        else $error("transmitter not halted on pause");
    jam_mode_a: assert property (@(posedge hclk) disable iff (!hresetn)
        jam_request |-> $past(!full_duplex && tx_flow_enable)) // [RL12] [RL13]
        else $error("jam outside half duplex back-pressure");
    mgmt_load_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (mgmt_read_done && !wr_pend) |=> mgmt_data_value == $past(mgmt_read_value)) // [RL1]
        else $error("management read value not held");
    vlan_status_a: assert property (@(posedge hclk) disable iff (!hresetn)
        p_done |=> rx_vlan_status == $past(p_vlan)) // [RL14]
        else $error("vlan status not updated");
    pause_cov_c: cover property (@(posedge hclk) pause_sent);
    halt_cov_c: cover property (@(posedge hclk) p_hit);
    jam_cov_c: cover property (@(posedge hclk) jam_request);
    vlan_cov_c: cover property (@(posedge hclk) p_done && p_vlan);
endmodule
`default_nettype wire

/* test/mfv_link_partner.sv */
// Far-side model: the link that delivers received frames and takes pause bytes.
// Assumes the bench fills rxq before send and sets slow to stall the pause stream.
`timescale 1ns/1ps
`default_nettype none
module mfv_link_partner (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Pause stream from the block
    input wire mfv_pkg::mfv_byte_type tx_out,
    output logic tx_ready,
    // Received stream and management read result
    output mfv_pkg::mfv_byte_type rx_in,
    output logic mgmt_read_done,
    output logic [15:0] mgmt_read_value
);
    import mfv_pkg::*;
    logic [7:0] rxq[$];
    logic [7:0] got[$];
    logic slow = 1'b0;
    integer sd = 7;
    // Quiet lines at time zero
    initial begin
        tx_ready = 1'b0;
        rx_in = '0;
        mgmt_read_done = 1'b0;
        mgmt_read_value = 16'h0;
    end
    // Take accepted pause bytes; stall at random when slow
    always @(posedge hclk) begin
        if (tx_out.valid === 1'b1 && tx_ready) got.push_back(tx_out.data);
        tx_ready <= hresetn && (!slow || $random(sd) % 2 != 0);
    end
    // One byte a cycle; idle data is the inverse of the last byte
    task automatic send();
        for (int i = 0; i < rxq.size(); i++) begin
            @(posedge hclk);
            rx_in <= {1'b1, i == 0, i == rxq.size() - 1, rxq[i]};
        end
        @(posedge hclk);
        rx_in <= {3'b000, ~rx_in.data};
    endtask
    // One-cycle management read completion
    task automatic mgmt(input logic [15:0] v);
        @(posedge hclk);
        mgmt_read_done <= 1'b1;
        mgmt_read_value <= v;
        @(posedge hclk);
        mgmt_read_done <= 1'b0;
        mgmt_read_value <= ~v;
    endtask
endmodule
`default_nettype wire

/* test/mfv_top_bench.sv */
// Self-checking bench for the flow-control and tag-match block.
// Assumes the package and the link partner model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module mfv_top_bench;
    import mfv_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [47:0] station_addr = 48'h0;
    logic [31:0] hrdata, rd, v;
    logic hreadyout, hresp, tx_ready, mgmt_read_done, tx_halt, jam_request;
    logic rx_vlan_status, rx_too_long;
    logic [15:0] mgmt_read_value, mgmt_data_value, pt, t;
    logic [15:0] halt_cnt = 16'h0;
    logic [15:0] jam_cnt = 16'h0;
    mfv_byte_type rx_in, tx_out;
    logic [7:0] exq[$];
    int err_total = 0;
    int n_checks = 0;
    int cyc = 0;
    integer seed = 32'hb438;
    ////////////////////////////////////////////////////////////////////////////////
    mfv_top mfv_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .mgmt_read_done(mgmt_read_done), .mgmt_read_value(mgmt_read_value),
        .mgmt_data_value(mgmt_data_value), .rx_in(rx_in), .station_addr(station_addr),
        .tx_ready(tx_ready), .tx_out(tx_out), .tx_halt(tx_halt),
        .jam_request(jam_request), .rx_vlan_status(rx_vlan_status),
        .rx_too_long(rx_too_long));
    mfv_link_partner mfv_link_partner_i (.hclk(hclk), .hresetn(hresetn), .tx_out(tx_out),
        .tx_ready(tx_ready), .rx_in(rx_in), .mgmt_read_done(mgmt_read_done),
        .mgmt_read_value(mgmt_read_value));
    // Clock at 40 MHz
    initial forever #12.5 hclk = ~hclk;
    // Cycle count, pulse counters and hang guard
    always @(posedge hclk) begin
        cyc++;
        if (tx_halt === 1'b1) halt_cnt++;
        if (jam_request === 1'b1) jam_cnt++;
        if (cyc == 20000) begin
            err_total++;
            end_sim();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic end_sim();
        if (err_total == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Frame bytes: header, then zero padding up to len
    function automatic void mk(input logic [47:0] da, input logic [15:0] ty, a, b, input int len);
        logic [143:0] h;
        h = {da, station_addr, ty, a, b};
        exq = {};
        for (int i = 0; i < len; i++) exq.push_back(i < 18 ? h[143 - 8 * i -: 8] : 8'h00);
    endfunction
    // Single AHB-Lite word transfer; read data lands in rd
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rdck(input logic [7:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        `CHK(rd, e)
        `CHK(hresp, 1'b0)
    endtask
    // Flow register write, spaced from the previous one
    task automatic wfl(input logic [31:0] d);
        repeat (4) @(posedge hclk);
        ahb(1'b1, MFV_ADDR_FLOW, d);
    endtask
    task automatic rxf(input logic [47:0] da, input logic [15:0] ty, a, b, input int len);
        mk(da, ty, a, b, len);
        mfv_link_partner_i.rxq = exq;
        mfv_link_partner_i.send();
        repeat (4) @(posedge hclk);
    endtask
    // Received pause frame of two quanta; count halted cycles
    task automatic pcase(input logic [31:0] d, input logic [47:0] da, input logic [15:0] e);
        logic [15:0] h0;
        wfl(d);
        h0 = halt_cnt;
        rxf(da, MFV_CTRL_TYPE, MFV_PAUSE_OP, 16'd2, 60);
        repeat (140) @(posedge hclk);
        `CHK(halt_cnt - h0, e)
    endtask
    task automatic jcase(input logic [31:0] d, input logic [15:0] e);
        logic [15:0] j0;
        wfl(d);
        j0 = jam_cnt;
        rxf(48'h0200_0000_0001, 16'h0800, 16'h0, 16'h0, 64);
        `CHK(jam_cnt - j0, e)
    endtask
    task automatic vcase(input logic [31:0] d, input logic [15:0] ty, tg, input logic e);
        ahb(1'b1, MFV_ADDR_VLAN, d);
        rdck(MFV_ADDR_VLAN, d & 32'h0001_ffff);
        rxf(48'h0200_0000_0001, ty, tg, 16'h0, 64);
        `CHK(rx_vlan_status, e)
    endtask
    task automatic lcase(input logic [15:0] ty, input int len, input logic e);
        rxf(48'h0200_0000_0001, ty, 16'h0, 16'h0, len);
        `CHK(rx_too_long, e)
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        station_addr = {16'h0200, $random(seed)};
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdck(MFV_ADDR_FLOW, 32'h0);
        rdck(MFV_ADDR_VLAN, 32'h0);
        rdck(MFV_ADDR_MODE, 32'h1);
        ahb(1'b1, 8'h40, 32'hffff_ffff);
        rdck(8'h40, 32'h0);
        v = $random(seed);
        ahb(1'b1, MFV_ADDR_MGMT, v);
        @(posedge hclk);
        `CHK(mgmt_data_value, v[15:0])
        rdck(MFV_ADDR_MGMT, {16'h0, v[15:0]});
        mfv_link_partner_i.mgmt(~v[15:0]);
        @(posedge hclk);
        `CHK(mgmt_data_value, ~v[15:0])
        wfl(32'hffff_fffe);
        rdck(MFV_ADDR_FLOW, 32'hffff_00be);
        pt = 16'($random(seed));
        mfv_link_partner_i.slow = 1'b1;
        mfv_link_partner_i.got = {};
        wfl({pt, 16'h0003});
        rdck(MFV_ADDR_FLOW, {pt, 16'h0003});
        for (int k = 0; k < 200 && rd[0] !== 1'b0; k++) ahb(1'b0, MFV_ADDR_FLOW, 32'h0);
        `CHK(rd[0], 1'b0)
        `CHK(mfv_link_partner_i.got.size(), 60)
        mk(MFV_PAUSE_DA, MFV_CTRL_TYPE, MFV_PAUSE_OP, pt, 60);
        foreach (exq[i]) `CHK(mfv_link_partner_i.got[i], exq[i])
        mfv_link_partner_i.got = {};
        wfl({pt, 16'h0001});
        repeat (100) @(posedge hclk);
        `CHK(mfv_link_partner_i.got.size(), 0)
        rdck(MFV_ADDR_FLOW, {pt, 16'h0000});
        pcase(32'h0000_0004, MFV_PAUSE_DA, 16'd128);
        pcase(32'h0000_0004, station_addr, 16'd0);
        pcase(32'h0000_000c, station_addr, 16'd128);
        pcase(32'h0000_0000, MFV_PAUSE_DA, 16'd0);
        ahb(1'b1, MFV_ADDR_MODE, 32'h0);
        jcase(32'h0000_0003, 16'd1);
        jcase(32'h0000_0001, 16'd0);
        ahb(1'b1, MFV_ADDR_MODE, 32'h1);
        t = 16'($random(seed)) | 16'h0001;
        vcase({16'h0, t}, MFV_VLAN_TYPE, t, 1'b1);
        vcase({16'h0, t}, MFV_VLAN_TYPE, t ^ 16'h8000, 1'b0);
        vcase({16'h1, t}, MFV_VLAN_TYPE, t ^ 16'he000, 1'b1);
        vcase({16'h1, t}, MFV_VLAN_TYPE, t ^ 16'h0800, 1'b0);
        vcase({16'h0, t}, 16'h0800, t, 1'b0);
        vcase(32'h0001_f000, MFV_VLAN_TYPE, t, 1'b1);
        vcase(32'h0, MFV_VLAN_TYPE, t, 1'b1);
        lcase(16'h0800, 1518, 1'b0);
        lcase(16'h0800, 1519, 1'b1);
        lcase(MFV_VLAN_TYPE, 1522, 1'b0);
        lcase(MFV_VLAN_TYPE, 1523, 1'b1);
        rdck(MFV_ADDR_STAT, 32'h0000_000c);
        end_sim();
    end
endmodule
`default_nettype wire
